// [rtl/irq_sleep_pkg.sv]
// constants, register map and state encodings of the interrupt enable and sleep block
// Operation
// - six request sources: two pins, three timers, one serial port
// - each source has its own enable bit; cleared bit blocks its request
// - bit 7 global enable blocks every request when zero
// - enable bits: 5 timer c, 4 serial, 3 timer b, 2 pin b, 1 timer a, 0 pin a
// - timer c request is overflow flag OR external flag
// - timer c flags survive vectoring; software clears whichever caused it
// - timer a/b flags set at state five phase two, sampled next cycle
// - timer c flag set at state two phase two, sampled same cycle
// - idle stops the core only; peripherals run, registers keep contents
// - idle ends on any enabled request or hardware reset
// - reset out of idle lets execution run up to two machine cycles
// - during those cycles ram writes blocked, port accesses allowed
// - power down stops oscillator after current instruction; contents kept
// - power down left only by hardware reset, never by interrupts
// - reset out of power down restores registers, leaves ram untouched
// - idle holds both strobes at one; power down holds both at zero
// - internal clock comes from a divide-by-two of the oscillator
package irq_sleep_pkg;
  // ***********************************
  // register map
  // ***********************************
  localparam logic [7:0] OFF_ENABLE = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_FLAGS = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] ENABLE_WMASK = 8'hbf;
  localparam int BIT_GLOBAL = 7;
  localparam int BIT_TMR_C = 5;
  localparam int BIT_SERIAL = 4;
  localparam int BIT_TMR_B = 3;
  localparam int BIT_EXT_B = 2;
  localparam int BIT_TMR_A = 1;
  localparam int BIT_EXT_A = 0;
  localparam int NUM_SRC = 6;
  localparam int SRC_W = 3;
  localparam int CTRL_IDLE = 0;
  localparam int CTRL_PDOWN = 1;
  localparam int FLAG_W = 4;
  localparam int FLG_TA = 0;
  localparam int FLG_TB = 1;
  localparam int FLG_TC_OVF = 2;
  localparam int FLG_TC_EXT = 3;
  localparam int ST_PEND = 8;
  localparam int ST_SRC_LSB = 9;
  localparam int ST_SLEEP_LSB = 12;
  // ***********************************
  // machine cycle timing
  // ***********************************
  localparam int STATE_W = 3;
  localparam logic [2:0] LAST_STATE = 3'h5;
  localparam logic [2:0] STATE_TWO = 3'h1;
  localparam logic [2:0] STATE_FIVE = 3'h4;
  localparam logic [1:0] GRACE_LAST = 2'h1;
  // ***********************************
  // sleep states, gray along run-idle-grace
  // ***********************************
  typedef enum logic [1:0] {
    SLP_RUN = 2'h0,
    SLP_IDLE = 2'h1,
    SLP_GRACE = 2'h3,
    SLP_PDOWN = 2'h2
  } sleep_e;
endpackage : irq_sleep_pkg

// [rtl/machine_cycle_timer.sv]
// machine cycle phase generator from a divide-by-two of the oscillator
`timescale 1ns/100ps
module machine_cycle_timer (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // oscillator running
  input wire logic run,
  // phase pulses
  output logic state_two_phase_two,
  output logic state_five_phase_two,
  output logic cycle_end
);
  logic half_q;
  logic half_d;
  logic [irq_sleep_pkg::STATE_W-1:0] state_q;
  logic [irq_sleep_pkg::STATE_W-1:0] state_d;

  // divide by two
  // duty cycle of the input never reaches internal timing
  always_comb begin
    half_d = half_q;
    state_d = state_q;
    if (run) begin
      half_d = ~half_q;
      if (half_q) begin
        if (state_q == irq_sleep_pkg::LAST_STATE) begin
          state_d = '0;
        end else begin
          state_d = state_q + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      half_q <= 1'b0;
      state_q <= '0;
    end else begin
      half_q <= half_d;
      state_q <= state_d;
    end
  end

  assign state_two_phase_two = run & half_q & (state_q == irq_sleep_pkg::STATE_TWO);
  assign state_five_phase_two = run & half_q & (state_q == irq_sleep_pkg::STATE_FIVE);
  assign cycle_end = run & half_q & (state_q == irq_sleep_pkg::LAST_STATE);
endmodule : machine_cycle_timer

// [rtl/irq_fixed_priority.sv]
// fixed order pick of the lowest numbered pending request
`timescale 1ns/100ps
module irq_fixed_priority (
  // pending requests
  input wire logic [irq_sleep_pkg::NUM_SRC-1:0] req,
  // winner
  output logic any,
  output logic [irq_sleep_pkg::SRC_W-1:0] idx
);
  logic [irq_sleep_pkg::NUM_SRC-1:0] lower;
  logic [irq_sleep_pkg::NUM_SRC-1:0] win;

  // fixed order
  // bit 0 beats every other source
  genvar i;
  generate
    for (i = 0; i < irq_sleep_pkg::NUM_SRC; i++) begin : g_pick
      if (i == 0) begin : g_first
        assign lower[i] = 1'b0;
      end else begin : g_rest
        assign lower[i] = lower[i-1] | req[i-1];
      end
      assign win[i] = req[i] & ~lower[i];
    end
  endgenerate

  always_comb begin
    idx = '0;
    for (int k = 0; k < irq_sleep_pkg::NUM_SRC; k++) begin
      if (win[k]) begin
        idx = k[irq_sleep_pkg::SRC_W-1:0];
      end
    end
  end

  assign any = |req;
endmodule : irq_fixed_priority

// [rtl/irq_sleep_ctrl.sv]
// interrupt enable, request sampling and idle/power down control with apb registers
`timescale 1ns/100ps
module irq_sleep_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // request sources
  input wire logic ext_irq_pin_a_n,
  input wire logic ext_irq_pin_b_n,
  input wire logic tmr_a_overflow,
  input wire logic tmr_b_overflow,
  input wire logic tmr_c_overflow,
  input wire logic tmr_c_external,
  input wire logic serial_irq_req,
  // core side
  input wire logic irq_ack,
  input wire logic [2:0] irq_ack_src,
  output logic irq_req,
  output logic [2:0] irq_src,
  input wire logic hw_reset,
  output logic core_reset,
  output logic cpu_run,
  output logic osc_enable,
  output logic ram_write_block,
  // pins
  input wire logic core_ale,
  input wire logic core_pss,
  input wire logic ext_prog_mem,
  output logic ale_out,
  output logic program_store_strobe,
  output logic port0_float,
  output logic port2_hold_addr
);
  // ***********************************
  // declarations
  // ***********************************
  logic state_two_phase_two;
  logic state_five_phase_two;
  logic cycle_end;
  logic sfr_rst;
  logic acc;
  logic wr;
  logic mapped;
  logic [7:0] irq_mask_q, irq_mask_d;
  logic [1:0] cmd_q, cmd_d;
  logic [irq_sleep_pkg::FLAG_W-1:0] flags_q, flags_d;
  logic [irq_sleep_pkg::FLAG_W-1:0] pend_q, pend_d;
  logic [irq_sleep_pkg::FLAG_W-1:0] wclr;
  logic [irq_sleep_pkg::NUM_SRC-1:0] samp_q, samp_d;
  logic [irq_sleep_pkg::NUM_SRC-1:0] req_vec;
  logic prio_any;
  logic [2:0] prio_idx;
  logic irq_req_q;
  logic [2:0] irq_src_q;
  logic [31:0] prdata_q, prdata_d;
  irq_sleep_pkg::sleep_e state_q, state_d;
  logic [1:0] grace_q, grace_d;
  logic core_rst_q, core_rst_d;
  logic ale_q, ale_d;
  logic pss_q, pss_d;
  logic p0f_q, p0f_d;
  logic p2a_q, p2a_d;

  // ***********************************
  // timing and priority
  // ***********************************
  machine_cycle_timer u_timer (
    .clk(clk),
    .rst(rst),
    .run(osc_enable),
    .state_two_phase_two(state_two_phase_two),
    .state_five_phase_two(state_five_phase_two),
    .cycle_end(cycle_end)
  );

  assign req_vec = samp_q & irq_mask_q[irq_sleep_pkg::NUM_SRC-1:0];

  irq_fixed_priority u_prio (
    .req(req_vec),
    .any(prio_any),
    .idx(prio_idx)
  );

  // ***********************************
  // apb access
  // ***********************************
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign mapped = (paddr == irq_sleep_pkg::OFF_ENABLE) | (paddr == irq_sleep_pkg::OFF_CTRL) |
                  (paddr == irq_sleep_pkg::OFF_FLAGS) | (paddr == irq_sleep_pkg::OFF_STATUS);
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata = prdata_q;
  assign wclr = (wr && paddr == irq_sleep_pkg::OFF_FLAGS) ? pwdata[irq_sleep_pkg::FLAG_W-1:0] : '0;
  // reset leaving sleep reloads every register but the sleep state, grace count, core reset, pin outputs and machine cycle timer
  assign sfr_rst = rst | core_rst_q;

  always_comb begin
    prdata_d = prdata_q;
    if (psel && !penable && !pwrite) begin
      prdata_d = '0;
      if (paddr == irq_sleep_pkg::OFF_ENABLE) begin
        prdata_d[7:0] = irq_mask_q;
      end else if (paddr == irq_sleep_pkg::OFF_CTRL) begin
        prdata_d[1:0] = cmd_q;
      end else if (paddr == irq_sleep_pkg::OFF_FLAGS) begin
        prdata_d[irq_sleep_pkg::FLAG_W-1:0] = flags_q;
      end else if (paddr == irq_sleep_pkg::OFF_STATUS) begin
        prdata_d[irq_sleep_pkg::NUM_SRC-1:0] = samp_q;
        prdata_d[irq_sleep_pkg::ST_PEND] = irq_req_q;
        prdata_d[irq_sleep_pkg::ST_SRC_LSB +: 3] = irq_src_q;
        prdata_d[irq_sleep_pkg::ST_SLEEP_LSB +: 2] = state_q;
      end
    end
  end

  // ***********************************
  // enable register, commands, flags
  // ***********************************
  always_comb begin
    irq_mask_d = irq_mask_q;
    cmd_d = cmd_q;
    // bit layout
    // reserved bit 6 never stores, reads zero
    if (wr && paddr == irq_sleep_pkg::OFF_ENABLE) begin
      irq_mask_d = pwdata[7:0] & irq_sleep_pkg::ENABLE_WMASK;
    end
    if (wr && paddr == irq_sleep_pkg::OFF_CTRL) begin
      cmd_d = cmd_q | pwdata[1:0];
    end
    if (state_q == irq_sleep_pkg::SLP_RUN && state_d != irq_sleep_pkg::SLP_RUN) begin
      cmd_d = '0;
    end
    pend_d = pend_q | {tmr_c_external, tmr_c_overflow, tmr_b_overflow, tmr_a_overflow};
    flags_d = flags_q & ~wclr;
    if (irq_ack && irq_ack_src == irq_sleep_pkg::BIT_TMR_A[2:0]) begin
      flags_d[irq_sleep_pkg::FLG_TA] = 1'b0;
    end
    if (irq_ack && irq_ack_src == irq_sleep_pkg::BIT_TMR_B[2:0]) begin
      flags_d[irq_sleep_pkg::FLG_TB] = 1'b0;
    end
    // timer a/b flags land at state five phase two
    // set after clear so a late event wins
    if (state_five_phase_two) begin
      flags_d[irq_sleep_pkg::FLG_TB:irq_sleep_pkg::FLG_TA] =
        flags_d[irq_sleep_pkg::FLG_TB:irq_sleep_pkg::FLG_TA] |
        pend_d[irq_sleep_pkg::FLG_TB:irq_sleep_pkg::FLG_TA];
      pend_d[irq_sleep_pkg::FLG_TB:irq_sleep_pkg::FLG_TA] = '0;
    end
    // timer c flags land at state two phase two
    if (state_two_phase_two) begin
      flags_d[irq_sleep_pkg::FLG_TC_EXT:irq_sleep_pkg::FLG_TC_OVF] =
        flags_d[irq_sleep_pkg::FLG_TC_EXT:irq_sleep_pkg::FLG_TC_OVF] |
        pend_d[irq_sleep_pkg::FLG_TC_EXT:irq_sleep_pkg::FLG_TC_OVF];
      pend_d[irq_sleep_pkg::FLG_TC_EXT:irq_sleep_pkg::FLG_TC_OVF] = '0;
    end
    samp_d = samp_q;
    // one sample point: a/b flags set here are seen next cycle
    if (state_five_phase_two) begin
      samp_d[irq_sleep_pkg::BIT_EXT_A] = ~ext_irq_pin_a_n;
      samp_d[irq_sleep_pkg::BIT_TMR_A] = flags_q[irq_sleep_pkg::FLG_TA];
      samp_d[irq_sleep_pkg::BIT_EXT_B] = ~ext_irq_pin_b_n;
      samp_d[irq_sleep_pkg::BIT_TMR_B] = flags_q[irq_sleep_pkg::FLG_TB];
      samp_d[irq_sleep_pkg::BIT_SERIAL] = serial_irq_req;
      // timer c request combines both flags
      samp_d[irq_sleep_pkg::BIT_TMR_C] = flags_q[irq_sleep_pkg::FLG_TC_OVF] |
                                         flags_q[irq_sleep_pkg::FLG_TC_EXT];
    end
  end

  always_ff @(posedge clk) begin
    if (sfr_rst) begin
      irq_mask_q <= irq_sleep_pkg::ENABLE_RESET;
      cmd_q <= '0;
      flags_q <= '0;
      pend_q <= '0;
      samp_q <= '0;
      irq_req_q <= 1'b0;
      irq_src_q <= '0;
      prdata_q <= '0;
    end else begin
      irq_mask_q <= irq_mask_d;
      cmd_q <= cmd_d;
      flags_q <= flags_d;
      pend_q <= pend_d;
      samp_q <= samp_d;
      irq_req_q <= irq_mask_q[irq_sleep_pkg::BIT_GLOBAL] & prio_any;
      irq_src_q <= prio_idx;
      prdata_q <= prdata_d;
    end
  end

  assign irq_req = irq_req_q;
  assign irq_src = irq_src_q;

  // ***********************************
  // sleep control
  // ***********************************
  always_comb begin
    state_d = state_q;
    grace_d = grace_q;
    case (state_q)
      irq_sleep_pkg::SLP_RUN: begin
        // enter at a cycle boundary, after the current instruction
        if (!hw_reset && cycle_end && cmd_q[irq_sleep_pkg::CTRL_PDOWN]) begin
          state_d = irq_sleep_pkg::SLP_PDOWN;
        end else if (!hw_reset && cycle_end && cmd_q[irq_sleep_pkg::CTRL_IDLE]) begin
          state_d = irq_sleep_pkg::SLP_IDLE;
        end
      end
      irq_sleep_pkg::SLP_IDLE: begin
        // wake on reset or enabled request
        if (hw_reset) begin
          state_d = irq_sleep_pkg::SLP_GRACE;
          grace_d = '0;
        end else if (irq_req_q) begin
          state_d = irq_sleep_pkg::SLP_RUN;
        end
      end
      irq_sleep_pkg::SLP_GRACE: begin
        // at most two machine cycles before reset takes over
        if (cycle_end) begin
          grace_d = grace_q + 2'h1;
          if (grace_q == irq_sleep_pkg::GRACE_LAST) begin
            state_d = irq_sleep_pkg::SLP_RUN;
          end
        end
      end
      irq_sleep_pkg::SLP_PDOWN: begin
        // only hardware reset leaves power down
        if (hw_reset) begin
          state_d = irq_sleep_pkg::SLP_RUN;
        end
      end
      default: begin
        state_d = irq_sleep_pkg::SLP_RUN;
      end
    endcase
    core_rst_d = hw_reset & (state_d == irq_sleep_pkg::SLP_RUN);
    ale_d = core_ale;
    pss_d = core_pss;
    if (state_d == irq_sleep_pkg::SLP_IDLE) begin
      ale_d = 1'b1;
      pss_d = 1'b1;
    end else if (state_d == irq_sleep_pkg::SLP_PDOWN) begin
      ale_d = 1'b0;
      pss_d = 1'b0;
    end
    // port behaviour with external program memory
    p0f_d = ext_prog_mem & ((state_d == irq_sleep_pkg::SLP_IDLE) |
                            (state_d == irq_sleep_pkg::SLP_PDOWN));
    p2a_d = ext_prog_mem & (state_d == irq_sleep_pkg::SLP_IDLE);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= irq_sleep_pkg::SLP_RUN;
      grace_q <= '0;
      core_rst_q <= 1'b0;
      ale_q <= 1'b0;
      pss_q <= 1'b0;
      p0f_q <= 1'b0;
      p2a_q <= 1'b0;
    end else begin
      state_q <= state_d;
      grace_q <= grace_d;
      core_rst_q <= core_rst_d;
      ale_q <= ale_d;
      pss_q <= pss_d;
      p0f_q <= p0f_d;
      p2a_q <= p2a_d;
    end
  end

  assign core_reset = core_rst_q;
  assign cpu_run = (state_q == irq_sleep_pkg::SLP_RUN) | (state_q == irq_sleep_pkg::SLP_GRACE);
  assign osc_enable = (state_q != irq_sleep_pkg::SLP_PDOWN);
  assign ram_write_block = (state_q == irq_sleep_pkg::SLP_GRACE);
  assign ale_out = ale_q;
  assign program_store_strobe = pss_q;
  assign port0_float = p0f_q;
  assign port2_hold_addr = p2a_q;

  // ***********************************
  // checks
  // ***********************************
  global_gate_a: assert property (@(posedge clk) disable iff (sfr_rst)
    !irq_mask_q[irq_sleep_pkg::BIT_GLOBAL] |=> !irq_req) else $error("request with global off");
  src_enable_a: assert property (@(posedge clk) disable iff (sfr_rst)
    irq_req |-> $past(req_vec[prio_idx])) else $error("request from disabled source");
  tmrc_or_a: assert property (@(posedge clk) disable iff (sfr_rst)
    state_five_phase_two && (flags_q[irq_sleep_pkg::FLG_TC_OVF] || flags_q[irq_sleep_pkg::FLG_TC_EXT])
    |=> samp_q[irq_sleep_pkg::BIT_TMR_C]) else $error("timer c request missing");
  tmrc_keep_a: assert property (@(posedge clk) disable iff (sfr_rst)
    irq_ack && flags_q[irq_sleep_pkg::FLG_TC_OVF] && !wclr[irq_sleep_pkg::FLG_TC_OVF]
    |=> flags_q[irq_sleep_pkg::FLG_TC_OVF]) else $error("timer c flag cleared by hardware");
  tmra_phase_a: assert property (@(posedge clk) disable iff (sfr_rst)
    $rose(flags_q[irq_sleep_pkg::FLG_TA]) |-> $past(state_five_phase_two)) else $error("timer a flag off phase");
  tmrc_phase_a: assert property (@(posedge clk) disable iff (sfr_rst)
    $rose(flags_q[irq_sleep_pkg::FLG_TC_OVF]) |-> $past(state_two_phase_two)) else $error("timer c off phase");
  idle_wake_a: assert property (@(posedge clk) disable iff (rst)
    state_q == irq_sleep_pkg::SLP_IDLE && irq_req && !hw_reset
    |=> state_q == irq_sleep_pkg::SLP_RUN) else $error("idle not left on request");
  grace_len_a: assert property (@(posedge clk) disable iff (rst)
    $rose(ram_write_block) |-> ##[1:26] !ram_write_block) else $error("grace too long");
  pdown_hold_a: assert property (@(posedge clk) disable iff (rst)
    state_q == irq_sleep_pkg::SLP_PDOWN && !hw_reset
    |=> state_q == irq_sleep_pkg::SLP_PDOWN) else $error("power down left without reset");
  idle_pins_a: assert property (@(posedge clk) disable iff (rst)
    state_q == irq_sleep_pkg::SLP_IDLE |-> ale_out && program_store_strobe)
    else $error("strobes not high in idle");
endmodule : irq_sleep_ctrl

// [testbench/core_model.sv]
// behavioural core: strobes and interrupt vectoring against the block
`timescale 1ns/100ps
module core_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // from the block
  input wire logic irq_req,
  input wire logic [2:0] irq_src,
  input wire logic cpu_run,
  // bench controls
  input wire logic ack_en,
  input wire logic slow,
  // to the block
  output logic irq_ack,
  output logic [2:0] irq_ack_src,
  output logic core_ale,
  output logic core_pss
);
  logic [2:0] dly_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      dly_q <= 3'h0;
      irq_ack <= 1'b0;
      irq_ack_src <= 3'h0;
      core_ale <= 1'b0;
      core_pss <= 1'b0;
    end else begin
      // strobes keep toggling so a held pin is really held by the block
      core_ale <= ~core_ale;
      core_pss <= core_ale;
      irq_ack <= 1'b0;
      // source lines idle with a changing pattern, never the last value
      irq_ack_src <= ~irq_ack_src;
      dly_q <= 3'h0;
      if (ack_en && irq_req && cpu_run && !irq_ack) begin
        dly_q <= dly_q + 3'h1;
        if (dly_q >= (slow ? 3'h4 : 3'h0)) begin
          irq_ack <= 1'b1;
          irq_ack_src <= irq_src;
          dly_q <= 3'h0;
        end
      end
    end
  end
endmodule : core_model

// [testbench/irq_enable_and_sleep_control_bench.sv]
// self-checking testbench of the interrupt enable and sleep block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module irq_enable_and_sleep_control_bench;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] lvl, ev;
  logic ev_x, hw_reset, ext_prog_mem, ack_en, slow, irq_ack, irq_req;
  logic core_reset, cpu_run, osc_enable, ram_write_block, core_ale, core_pss;
  logic ale_out, program_store_strobe, port0_float, port2_hold_addr;
  logic [2:0] irq_ack_src, irq_src;
  int failures, n_checks, n;
  irq_sleep_ctrl DUT (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_irq_pin_a_n(~lvl[0]), .ext_irq_pin_b_n(~lvl[2]), .tmr_a_overflow(ev[1]),
    .tmr_b_overflow(ev[3]), .tmr_c_overflow(ev[5]), .tmr_c_external(ev_x),
    .serial_irq_req(lvl[4]), .irq_ack(irq_ack), .irq_ack_src(irq_ack_src), .irq_req(irq_req),
    .irq_src(irq_src), .hw_reset(hw_reset), .core_reset(core_reset), .cpu_run(cpu_run),
    .osc_enable(osc_enable), .ram_write_block(ram_write_block), .core_ale(core_ale),
    .core_pss(core_pss), .ext_prog_mem(ext_prog_mem), .ale_out(ale_out),
    .program_store_strobe(program_store_strobe), .port0_float(port0_float),
    .port2_hold_addr(port2_hold_addr));
  core_model core (.clk(clk), .rst(rst), .irq_req(irq_req), .irq_src(irq_src),
    .cpu_run(cpu_run), .ack_en(ack_en), .slow(slow), .irq_ack(irq_ack),
    .irq_ack_src(irq_ack_src), .core_ale(core_ale), .core_pss(core_pss));
  // ***********************************
  // tasks
  // ***********************************
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask : rchk
  task wt(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : wt
  task wirq;
    n = 0;
    do begin
      wt(1);
      n++;
    end while (irq_req !== 1'b1 && n < 40);
  endtask : wirq
  task wait_run(input logic v);
    n = 0;
    do begin
      wt(1);
      n++;
    end while (cpu_run !== v && n < 40);
  endtask : wait_run
  task fire(input int i);
    @(posedge clk);
    if (i == 1 || i == 3 || i == 5) ev[i] <= 1'b1;
    else lvl[i] <= 1'b1;
    @(posedge clk);
    ev <= 6'h00;
  endtask : fire
  task quiet;
    @(posedge clk);
    lvl <= 6'h00;
    apb(1'b1, 8'h08, 32'hf);
    wt(26);
  endtask : quiet
  // ***********************************
  // clock, watchdog, tests
  // ***********************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // run needs about 1000 cycles; limit well beyond that
  initial begin
    repeat (8000) @(posedge clk);
    failures++;
    end_sim;
  end
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {3'h4, 41'h0};
    {lvl, ev, ev_x, hw_reset, ack_en, slow} = 16'h0;
    ext_prog_mem = 1'b1;
    failures = 0;
    n_checks = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rchk(8'h00, 32'h0, "enable reset");
    rchk(8'h0c, 32'h0, "status reset");
    rchk(8'h10, 32'h0, "unmapped read");
    `CHK("unmapped err", 1'b1, err)
    apb(1'b1, 8'h00, 32'hbf);
    rchk(8'h00, 32'hbf, "enable mask");
    apb(1'b1, 8'h0c, 32'hffffffff);
    rchk(8'h0c, 32'h0, "status read only");
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 8'h00, 32'h80 | (32'h1 << i));
      fire(i);
      wirq;
      `CHK("irq on", 1'b1, irq_req)
      `CHK("irq src", 3'(i), irq_src)
      if (i == 1 || i == 3) `CHK("tmr ab delay", 1'b1, n > 12 && n <= 25)
      if (i == 5) `CHK("tmr c delay", 1'b1, n <= 19)
      apb(1'b1, 8'h00, 32'h1 << i);
      wt(14);
      `CHK("global off", 1'b0, irq_req)
      apb(1'b1, 8'h00, 32'hbf & ~(32'h1 << i));
      wt(14);
      `CHK("source off", 1'b0, irq_req)
      quiet;
    end
    $display("test enables done");
    @(posedge clk);
    ack_en <= 1'b1;
    apb(1'b1, 8'h00, 32'ha0);
    fire(5);
    wirq;
    wt(12);
    rchk(8'h08, 32'h4, "tc flag kept");
    `CHK("tc irq held", 1'b1, irq_req)
    apb(1'b1, 8'h08, 32'h4);
    wt(26);
    `CHK("tc irq cleared", 1'b0, irq_req)
    @(posedge clk);
    ev_x <= 1'b1;
    @(posedge clk);
    ev_x <= 1'b0;
    wirq;
    `CHK("tc ext src", 3'h5, irq_src)
    rchk(8'h08, 32'h8, "tc ext flag");
    slow <= 1'b1;
    apb(1'b1, 8'h00, 32'h82);
    fire(1);
    wirq;
    wt(20);
    rchk(8'h08, 32'h8, "ta flag acked");
    ack_en <= 1'b0;
    slow <= 1'b0;
    quiet;
    apb(1'b1, 8'h00, 32'hbf);
    @(posedge clk);
    lvl <= 6'h11;
    wirq;
    wt(2);
    `CHK("first winner", 3'h0, irq_src)
    @(posedge clk);
    lvl <= 6'h10;
    wt(26);
    `CHK("next winner", 3'h4, irq_src)
    quiet;
    $display("test flags and order done");
    apb(1'b1, 8'h00, 32'h90);
    apb(1'b1, 8'h04, 32'h1);
    wait_run(1'b0);
    `CHK("idle core", 1'b0, cpu_run)
    `CHK("idle osc", 1'b1, osc_enable)
    `CHK("idle strobes", 2'h3, {ale_out, program_store_strobe})
    `CHK("idle ports", 2'h3, {port0_float, port2_hold_addr})
    rchk(8'h00, 32'h90, "enable kept");
    fire(0);
    wt(30);
    `CHK("disabled no wake", 1'b0, cpu_run)
    fire(4);
    wait_run(1'b1);
    `CHK("idle wake", 1'b1, cpu_run)
    quiet;
    apb(1'b1, 8'h04, 32'h1);
    wait_run(1'b0);
    @(posedge clk);
    hw_reset <= 1'b1;
    wt(2);
    `CHK("grace run", 1'b1, cpu_run)
    `CHK("ram blocked", 1'b1, ram_write_block)
    n = 0;
    while (ram_write_block === 1'b1 && n < 40) begin
      wt(1);
      n++;
    end
    `CHK("grace length", 1'b1, n >= 10 && n <= 23)
    wt(3);
    `CHK("reset after grace", 1'b1, core_reset)
    @(posedge clk);
    hw_reset <= 1'b0;
    wt(3);
    rchk(8'h00, 32'h0, "enable after reset");
    $display("test idle done");
    apb(1'b1, 8'h00, 32'h90);
    apb(1'b1, 8'h04, 32'h2);
    wait_run(1'b0);
    `CHK("pdown osc", 1'b0, osc_enable)
    `CHK("pdown strobes", 2'h0, {ale_out, program_store_strobe})
    `CHK("pdown ports", 2'h2, {port0_float, port2_hold_addr})
    @(posedge clk);
    ext_prog_mem <= 1'b0;
    wt(2);
    `CHK("pdown int ports", 2'h0, {port0_float, port2_hold_addr})
    fire(4);
    wt(30);
    `CHK("irq no wake", 2'h0, {cpu_run, osc_enable})
    @(posedge clk);
    // reset held while the oscillator restarts
    hw_reset <= 1'b1;
    wt(2);
    `CHK("reset wakes", 2'h3, {cpu_run, osc_enable})
    wt(2);
    `CHK("pdown core reset", 1'b1, core_reset)
    wt(4);
    @(posedge clk);
    hw_reset <= 1'b0;
    lvl <= 6'h00;
    wt(3);
    rchk(8'h00, 32'h0, "enable restored");
    $display("test power down done");
    end_sim;
  end
endmodule : irq_enable_and_sleep_control_bench
